// ### inc/mic_pkg.sv
// Purpose: shared constants for the interrupt code reporting block
// Assumes: 32-bit APB, one 10 MHz clock
// Notes: register offsets are byte addresses of aligned words
package mic_pkg;
   // clock and load timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int LOAD_TIME_NS = 400;
   localparam int LOAD_CYCLES =
      (LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // register byte offsets
   localparam logic [7:0] OFS_RX_CHAR = 8'h00;
   localparam logic [7:0] OFS_TXCOND = 8'h04;
   localparam logic [7:0] OFS_SEL = 8'h08;
   localparam logic [7:0] OFS_ACCESS = 8'h0c;
   localparam logic [7:0] OFS_LCLOAD = 8'h10;
   localparam logic [7:0] OFS_INT_STAT = 8'h14;
   localparam logic [7:0] OFS_INT_MASK = 8'h18;
   // field positions
   localparam int CODE_LSB = 12;
   localparam int LINE_LSB = 8;
   localparam int TXCODE_LSB = 8;
   localparam int LC_BUSY_BIT = 15;
   localparam int INT_RX_BIT = 0;
   localparam int INT_TX_BIT = 1;
   // reset values
   localparam logic [15:0] RX_CHAR_RESET = 16'h0000;
   localparam logic [15:0] TXCOND_RESET = 16'h0000;
   localparam logic [15:0] SEL_RESET = 16'h0000;
   localparam logic [1:0] INT_MASK_RESET = 2'h0;
   // receive codes, asynchronous lines
   localparam logic [3:0] RX_SPECIAL = 4'h0;
   localparam logic [3:0] RX_PARITY = 4'h1;
   localparam logic [3:0] RX_OVERRUN = 4'h2;
   localparam logic [3:0] RX_FRAMING = 4'h3;
   localparam logic [3:0] RX_BC_WARN = 4'h4;
   localparam logic [3:0] RX_BCC_DONE = 4'h5;
   localparam logic [3:0] RX_BC_ZERO = 4'h8;
   localparam logic [3:0] RX_STORE_NXM = 4'hc;
   localparam logic [3:0] RX_CTL_NXM = 4'hd;
   localparam logic [3:0] RX_STORE_PAR = 4'he;
   localparam logic [3:0] RX_CTL_PAR = 4'hf;
   // transmit condition kinds and codes
   localparam logic [2:0] TXK_PRI_NXM = 3'h0;
   localparam logic [2:0] TXK_PRI_BC0 = 3'h1;
   localparam logic [2:0] TXK_ALT_NXM = 3'h2;
   localparam logic [2:0] TXK_ALT_BC0 = 3'h3;
   localparam logic [2:0] TXK_CTL_NXM = 3'h4;
   localparam logic [2:0] TXK_CTL_PAR = 3'h5;
   localparam logic [3:0] TX_PRI_NXM = 4'h0;
   localparam logic [3:0] TX_PRI_BC0 = 4'h1;
   localparam logic [3:0] TX_ALT_NXM = 4'h2;
   localparam logic [3:0] TX_ALT_BC0 = 4'h3;
   localparam logic [3:0] TX_CTL_ERR = 4'h8;
   // line state secondary register index and its error bits
   localparam logic [3:0] LINE_STATE_IDX = 4'hf;
   localparam int LS_NXM_BIT = 0;
   localparam int LS_PAR_BIT = 1;
   // load sequencer states
   typedef enum logic [1:0] {
      LD_IDLE = 2'b01,
      LD_BUSY = 2'b10
   } mic_load_e;
endpackage

// ### hw/mic_report.sv
// Purpose: receive and transmit interrupt code reporting, secondary access
// Assumes: event inputs come from logic on clock_i; APB slave, zero wait
// Notes: secondary storage is 16 lines by 16 registers of 16 bits
`timescale 1ns/1ns
module mic_report
   import mic_pkg::*;
#(
   parameter int LINES = 16,
   parameter int SECS = 16
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // receive event from the line logic
   input wire logic rx_evt_i,
   input wire logic rx_async_i,
   input wire logic [3:0] rx_line_i,
   input wire logic [7:0] rx_char_i,
   input wire logic [3:0] rx_sync_code_i,
   input wire logic rx_special_i,
   input wire logic rx_parity_err_i,
   input wire logic rx_overrun_i,
   input wire logic rx_framing_err_i,
   input wire logic rx_bc_warn_i,
   input wire logic rx_bcc_done_i,
   input wire logic rx_bc_zero_i,
   input wire logic rx_store_nxm_i,
   input wire logic rx_ctl_nxm_i,
   input wire logic rx_store_par_i,
   input wire logic rx_ctl_par_i,
   // transmit event from the line logic
   input wire logic tx_evt_i,
   input wire logic [3:0] tx_line_i,
   input wire logic [2:0] tx_kind_i,
   // line control load toward the line cards
   output logic lc_load_o,
   output logic [3:0] lc_line_o,
   output logic [14:0] lc_data_o,
   // rx character discard and interrupt
   output logic rx_discard_o,
   output logic irq_o
);
   localparam int CW = $clog2(LOAD_CYCLES + 1);

   logic [15:0] rx_interrupt_char_reg;
   logic [15:0] txcond_reg;
   logic [15:0] sel_reg;
   logic [14:0] lc_data_reg;
   logic [3:0] lc_line_reg;
   logic lc_load_reg;
   logic [CW-1:0] ld_cnt_reg;
   mic_load_e ld_state_reg;
   logic [1:0] int_stat_reg;
   logic [1:0] int_mask_reg;
   logic [31:0] prdata_reg;
   logic discard_reg;
   logic [15:0] sec_mem [LINES*SECS];
   logic [3:0] rx_code_next;
   logic [3:0] tx_code_next;
   logic [7:0] sec_idx;
   logic [7:0] ls_idx;
   logic [15:0] acc_word;
   logic setup_ph;
   logic wr_acc;
   logic addr_ok;
   logic tx_ctl_err;
   logic lc_busy;

   // apb phases: read data is captured in setup so the access phase needs no wait
   assign setup_ph = psel_i && !penable_i;
   assign wr_acc = psel_i && penable_i && pwrite_i;
   assign pready_o = 1'b1;
   assign addr_ok = paddr_i == OFS_RX_CHAR || paddr_i == OFS_TXCOND ||
      paddr_i == OFS_SEL || paddr_i == OFS_ACCESS ||
      paddr_i == OFS_LCLOAD || paddr_i == OFS_INT_STAT ||
      paddr_i == OFS_INT_MASK;
   assign pslverr_o = psel_i && penable_i && !addr_ok;
   assign prdata_o = prdata_reg;
   assign lc_busy = ld_state_reg == LD_BUSY;

   // secondary word chosen by line bits 0-3 and register bits 8-11
   assign sec_idx = {sel_reg[3:0], sel_reg[11:8]};
   assign ls_idx = {tx_line_i, LINE_STATE_IDX};
   assign acc_word = sec_mem[sec_idx];
   assign tx_ctl_err = tx_evt_i &&
      (tx_kind_i == TXK_CTL_NXM || tx_kind_i == TXK_CTL_PAR);

   // receive code: processing errors first, then overrun over framing over
   // parity so a multi-error character never shows the parity code
   always_comb begin
      if (!rx_async_i) begin
         rx_code_next = rx_sync_code_i;
      end else if (rx_ctl_par_i) begin
         rx_code_next = RX_CTL_PAR;
      end else if (rx_store_par_i) begin
         rx_code_next = RX_STORE_PAR;
      end else if (rx_ctl_nxm_i) begin
         rx_code_next = RX_CTL_NXM;
      end else if (rx_store_nxm_i) begin
         rx_code_next = RX_STORE_NXM;
      end else if (rx_bc_zero_i) begin
         rx_code_next = RX_BC_ZERO;
      end else if (rx_overrun_i) begin
         rx_code_next = RX_OVERRUN;
      end else if (rx_framing_err_i) begin
         rx_code_next = RX_FRAMING;
      end else if (rx_parity_err_i) begin
         rx_code_next = RX_PARITY;
      end else if (rx_bcc_done_i) begin
         rx_code_next = RX_BCC_DONE;
      end else if (rx_bc_warn_i) begin
         rx_code_next = RX_BC_WARN;
      end else if (rx_special_i) begin
         rx_code_next = RX_SPECIAL;
      end else begin
         // no flag at all still falls on a defined code, never a reserved one
         rx_code_next = RX_SPECIAL;
      end
   end

   // transmit condition code
   always_comb begin
      unique case (tx_kind_i)
         TXK_PRI_NXM: tx_code_next = TX_PRI_NXM;
         TXK_PRI_BC0: tx_code_next = TX_PRI_BC0;
         TXK_ALT_NXM: tx_code_next = TX_ALT_NXM;
         TXK_ALT_BC0: tx_code_next = TX_ALT_BC0;
         default: tx_code_next = TX_CTL_ERR;
      endcase
   end

   // receive interrupt character register: code, line, character
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_interrupt_char_reg <= RX_CHAR_RESET;
      end else if (rx_evt_i) begin
         rx_interrupt_char_reg <= {rx_code_next, rx_line_i, rx_char_i};
      end
   end

   // discard pulse when storage was already exhausted on an async line
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         discard_reg <= 1'b0;
      end else begin
         discard_reg <= rx_evt_i && rx_async_i && rx_bc_zero_i;
      end
   end
   assign rx_discard_o = discard_reg;

   // transmit condition status: code in 8-11, line in 0-3
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         txcond_reg <= TXCOND_RESET;
      end else if (tx_evt_i) begin
         txcond_reg <= {4'h0, tx_code_next, 4'h0, tx_line_i};
      end
   end

   // secondary select register; host waits for load done before changing
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sel_reg <= SEL_RESET;
      end else if (wr_acc && paddr_i == OFS_SEL) begin
         sel_reg <= pwdata_i[15:0];
      end
   end

   // secondary storage: host access plus hardware logging of tx control fetch
   // errors; a same-cycle collision keeps the host data and ors the error
   always_ff @(posedge clock_i) begin
      if (wr_acc && paddr_i == OFS_ACCESS) begin
         sec_mem[sec_idx] <= pwdata_i[15:0];
      end
      if (tx_ctl_err) begin
         if (wr_acc && paddr_i == OFS_ACCESS && sec_idx == ls_idx) begin
            sec_mem[ls_idx] <= pwdata_i[15:0] |
               {14'h0, tx_kind_i == TXK_CTL_PAR, tx_kind_i == TXK_CTL_NXM};
         end else begin
            sec_mem[ls_idx][LS_NXM_BIT] <= tx_kind_i == TXK_CTL_NXM;
            sec_mem[ls_idx][LS_PAR_BIT] <= tx_kind_i == TXK_CTL_PAR;
         end
      end
   end

   // line control load: busy for a fixed time, then one load pulse
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ld_state_reg <= LD_IDLE;
         ld_cnt_reg <= '0;
         lc_load_reg <= 1'b0;
         lc_line_reg <= 4'h0;
         lc_data_reg <= 15'h0000;
      end else begin
         lc_load_reg <= 1'b0;
         unique case (ld_state_reg)
            LD_IDLE: begin
               if (wr_acc && paddr_i == OFS_LCLOAD) begin
                  lc_data_reg <= pwdata_i[14:0];
                  lc_line_reg <= sel_reg[3:0];
                  ld_cnt_reg <= CW'(LOAD_CYCLES - 1);
                  ld_state_reg <= LD_BUSY;
               end
            end
            LD_BUSY: begin
               if (ld_cnt_reg == '0) begin
                  lc_load_reg <= 1'b1;
                  ld_state_reg <= LD_IDLE;
               end else begin
                  ld_cnt_reg <= ld_cnt_reg - 1'b1;
               end
            end
         endcase
      end
   end
   assign lc_load_o = lc_load_reg;
   assign lc_line_o = lc_line_reg;
   assign lc_data_o = lc_data_reg;

   // sticky interrupt status: a new event wins over a write-one clear
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         int_stat_reg <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == INT_RX_BIT && rx_evt_i) ||
                (i == INT_TX_BIT && tx_evt_i)) begin
               int_stat_reg[i] <= 1'b1;
            end else if (wr_acc && paddr_i == OFS_INT_STAT &&
                         pwdata_i[i]) begin
               int_stat_reg[i] <= 1'b0;
            end
         end
      end
   end

   // interrupt mask
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         int_mask_reg <= INT_MASK_RESET;
      end else if (wr_acc && paddr_i == OFS_INT_MASK) begin
         int_mask_reg <= pwdata_i[1:0];
      end
   end
   assign irq_o = |(int_stat_reg & int_mask_reg);

   // read data captured in the setup cycle; unmapped reads give zero
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prdata_reg <= 32'h0;
      end else if (setup_ph) begin
         unique case (paddr_i)
            OFS_RX_CHAR: prdata_reg <= {16'h0, rx_interrupt_char_reg};
            OFS_TXCOND: prdata_reg <= {16'h0, txcond_reg};
            OFS_SEL: prdata_reg <= {16'h0, sel_reg};
            OFS_ACCESS: prdata_reg <= {16'h0, acc_word};
            OFS_LCLOAD: prdata_reg <= {16'h0, lc_busy, lc_data_reg};
            OFS_INT_STAT: prdata_reg <= {30'h0, int_stat_reg};
            OFS_INT_MASK: prdata_reg <= {30'h0, int_mask_reg};
            default: prdata_reg <= 32'h0;
         endcase
      end
   end

   // checks on the reporting logic
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);

   a_rx_bc_zero: assert property (
      rx_evt_i && rx_async_i && rx_bc_zero_i && !rx_store_nxm_i &&
      !rx_ctl_nxm_i && !rx_store_par_i && !rx_ctl_par_i
      |=> rx_interrupt_char_reg[15:12] == 4'h8 && rx_discard_o)
      else $error("byte count zero code wrong");
   a_rx_discard_only: assert property (
      rx_discard_o |-> $past(rx_evt_i && rx_async_i && rx_bc_zero_i))
      else $error("discard without exhausted count");
   a_rx_store_nxm: assert property (
      rx_evt_i && rx_async_i && rx_store_nxm_i && !rx_ctl_nxm_i &&
      !rx_store_par_i && !rx_ctl_par_i
      |=> rx_interrupt_char_reg[15:12] == 4'hc &&
      rx_interrupt_char_reg[7:0] == $past(rx_char_i))
      else $error("store nxm code wrong");
   a_rx_ctl_nxm: assert property (
      rx_evt_i && rx_async_i && rx_ctl_nxm_i && !rx_store_par_i &&
      !rx_ctl_par_i |=> rx_interrupt_char_reg[15:12] == 4'hd)
      else $error("control nxm code wrong");
   a_rx_store_par: assert property (
      rx_evt_i && rx_async_i && rx_store_par_i && !rx_ctl_par_i
      |=> rx_interrupt_char_reg[15:12] == 4'he)
      else $error("store parity code wrong");
   a_rx_ctl_par: assert property (
      rx_evt_i && rx_async_i && rx_ctl_par_i
      |=> rx_interrupt_char_reg[15:12] == 4'hf)
      else $error("control parity code wrong");
   a_rx_overrun_wins: assert property (
      rx_evt_i && rx_async_i && rx_overrun_i && !rx_bc_zero_i &&
      !rx_store_nxm_i && !rx_ctl_nxm_i && !rx_store_par_i && !rx_ctl_par_i
      |=> rx_interrupt_char_reg[15:12] == 4'h2)
      else $error("overrun not reported alone");
   a_rx_frame_wins: assert property (
      rx_evt_i && rx_async_i && rx_framing_err_i && !rx_overrun_i &&
      !rx_bc_zero_i && !rx_store_nxm_i && !rx_ctl_nxm_i &&
      !rx_store_par_i && !rx_ctl_par_i
      |=> rx_interrupt_char_reg[15:12] == 4'h3)
      else $error("framing not reported over parity");
   a_rx_par_alone: assert property (
      rx_evt_i && rx_async_i && (rx_overrun_i || rx_framing_err_i)
      |=> rx_interrupt_char_reg[15:12] != 4'h1)
      else $error("parity code on multiple error");
   a_rx_sync_pass: assert property (
      rx_evt_i && !rx_async_i
      |=> rx_interrupt_char_reg[15:12] == $past(rx_sync_code_i))
      else $error("sync code altered");
   a_tx_code_map: assert property (
      tx_evt_i && tx_kind_i <= 3'h3
      |=> txcond_reg[11:8] == {1'b0, $past(tx_kind_i)})
      else $error("transmit code wrong");
   a_tx_line_field: assert property (
      tx_evt_i |=> txcond_reg[3:0] == $past(tx_line_i))
      else $error("transmit line not reported");
   a_tx_ctl_log: assert property (
      tx_ctl_err
      |=> txcond_reg[11:8] == 4'h8 &&
      sec_mem[$past(ls_idx)][1:0] ==
      (($past(tx_kind_i) == 3'h5) ? 2'h2 : 2'h1))
      else $error("control fetch error not logged");
   a_lc_load_line: assert property (
      wr_acc && paddr_i == OFS_LCLOAD && !lc_busy
      |=> lc_busy [*4] ##1 lc_load_o &&
      lc_line_o == $past(sel_reg[3:0], 5))
      else $error("line control load wrong");
   a_access_read: assert property (
      setup_ph && paddr_i == OFS_ACCESS
      |=> prdata_o[15:0] == $past(acc_word))
      else $error("access read mismatch");
   a_rx_line_field: assert property (
      rx_evt_i
      |=> rx_interrupt_char_reg[11:8] == $past(rx_line_i))
      else $error("line number not reported");
   a_rx_no_reserved: assert property (
      rx_evt_i && rx_async_i
      |=> !(rx_interrupt_char_reg[15:12] inside
      {4'h6, 4'h7, 4'h9, 4'ha, 4'hb}))
      else $error("reserved code produced");
   // a new event must set its status bit even under a same-cycle clear
   a_int_rx_set: assert property (
      rx_evt_i |=> int_stat_reg[INT_RX_BIT])
      else $error("receive status not set");
   a_int_tx_set: assert property (
      tx_evt_i |=> int_stat_reg[INT_TX_BIT])
      else $error("transmit status not set");

   c_rx_overrun_mix: cover property (rx_evt_i && rx_async_i &&
      rx_overrun_i && rx_parity_err_i);
   c_rx_sync: cover property (rx_evt_i && !rx_async_i);
   c_tx_ctl_err: cover property (tx_ctl_err);
   c_lc_load: cover property (lc_load_o);
   c_irq: cover property ($rose(irq_o));
endmodule // mic_report

// ### verif/mic_line_model.sv
// Purpose: line-logic model that raises receive and transmit events
// Assumes: calls are made from the bench's single stimulus thread
// Notes: character, flags and kind are inverted once an event ends; line, sync and async fields hold
`timescale 1ns/1ns
module mic_line_model (
   // clock
   input wire logic clock_i,
   // receive event
   output logic rx_evt_o,
   output logic rx_async_o,
   output logic [3:0] rx_line_o,
   output logic [7:0] rx_char_o,
   output logic [3:0] rx_sync_o,
   output logic [10:0] rx_flags_o,
   // transmit event
   output logic tx_evt_o,
   output logic [3:0] tx_line_o,
   output logic [2:0] tx_kind_o
);
   // quiet lines at time zero
   initial begin
      rx_evt_o = 1'b0;
      rx_async_o = 1'b0;
      rx_line_o = 4'h0;
      rx_char_o = 8'h00;
      rx_sync_o = 4'h0;
      rx_flags_o = 11'h000;
      tx_evt_o = 1'b0;
      tx_line_o = 4'h0;
      tx_kind_o = 3'h0;
   end

   // one received character, valid for exactly one edge
   task automatic send_rx(input logic a, input logic [3:0] l,
                          input logic [7:0] c, input logic [3:0] s,
                          input logic [10:0] f);
      @(posedge clock_i);
      rx_evt_o <= 1'b1;
      rx_async_o <= a;
      rx_line_o <= l;
      rx_char_o <= c;
      rx_sync_o <= s;
      rx_flags_o <= f;
      @(posedge clock_i);
      rx_evt_o <= 1'b0;
      rx_char_o <= ~c; // no stale character after the pulse
      rx_flags_o <= ~f;
   endtask

   // one transmit condition pulse
   task automatic send_tx(input logic [3:0] l, input logic [2:0] k);
      @(posedge clock_i);
      tx_evt_o <= 1'b1;
      tx_line_o <= l;
      tx_kind_o <= k;
      @(posedge clock_i);
      tx_evt_o <= 1'b0;
      tx_kind_o <= ~k;
   endtask
endmodule // mic_line_model

// ### verif/mic_report_tb_top.sv
// Purpose: self-checking bench for the interrupt code reporting block
// Assumes: zero-wait APB slave, events from the line-logic model
// Notes: reads queue their expectation; a monitor pops and compares
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module mic_report_tb_top;
   import mic_pkg::*;
   logic clock_i = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, lc_load_o, rx_discard_o, irq_o;
   logic [3:0] lc_line_o;
   logic [14:0] lc_data_o;
   logic rx_evt, rx_async, tx_evt;
   logic [3:0] rx_line, rx_sync, tx_line;
   logic [7:0] rx_char;
   logic [10:0] rxf;
   logic [2:0] tx_kind;
   logic [32:0] rd_q[$];
   logic [18:0] lc_q[$];
   logic [32:0] mon_exp;
   logic [31:0] seed = 32'h55e1608c;
   logic [3:0] txc[8] = '{TX_PRI_NXM, TX_PRI_BC0, TX_ALT_NXM, TX_ALT_BC0,
                          TX_CTL_ERR, TX_CTL_ERR, TX_CTL_ERR, TX_CTL_ERR};
   int n_errors = 0;
   int check_count = 0;
   int n_disc = 0;
   int exp_disc = 0;
   int cyc = 0;

   always #50 clock_i = ~clock_i;

   mic_line_model i_mic_line_model (.clock_i(clock_i), .rx_evt_o(rx_evt),
      .rx_async_o(rx_async), .rx_line_o(rx_line), .rx_char_o(rx_char),
      .rx_sync_o(rx_sync), .rx_flags_o(rxf), .tx_evt_o(tx_evt),
      .tx_line_o(tx_line), .tx_kind_o(tx_kind));

   mic_report i_mic_report (.clock_i(clock_i), .reset_n_i(reset_n),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_evt_i(rx_evt),
      .rx_async_i(rx_async), .rx_line_i(rx_line), .rx_char_i(rx_char),
      .rx_sync_code_i(rx_sync), .rx_special_i(rxf[0]),
      .rx_bc_warn_i(rxf[1]), .rx_bcc_done_i(rxf[2]),
      .rx_parity_err_i(rxf[3]), .rx_framing_err_i(rxf[4]),
      .rx_overrun_i(rxf[5]), .rx_bc_zero_i(rxf[6]),
      .rx_store_nxm_i(rxf[7]), .rx_ctl_nxm_i(rxf[8]),
      .rx_store_par_i(rxf[9]), .rx_ctl_par_i(rxf[10]), .tx_evt_i(tx_evt),
      .tx_line_i(tx_line), .tx_kind_i(tx_kind), .lc_load_o(lc_load_o),
      .lc_line_o(lc_line_o), .lc_data_o(lc_data_o),
      .rx_discard_o(rx_discard_o), .irq_o(irq_o));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // expected async code: the highest set flag wins
   function automatic logic [3:0] prio(input logic [10:0] f);
      logic [3:0] c[11] = '{RX_SPECIAL, RX_BC_WARN, RX_BCC_DONE, RX_PARITY,
         RX_FRAMING, RX_OVERRUN, RX_BC_ZERO, RX_STORE_NXM, RX_CTL_NXM,
         RX_STORE_PAR, RX_CTL_PAR};
      prio = RX_SPECIAL;
      for (int i = 0; i < 11; i++) begin
         if (f[i]) prio = c[i];
      end
   endfunction

   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // setup, then access held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clock_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      @(posedge clock_i);
      while (pready_o !== 1'b1) @(posedge clock_i);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic err = 1'b0);
      rd_q.push_back({err, e});
      apb(1'b0, a, rnd());
   endtask

   // one character event, then its report word read back
   task automatic rx(input logic a, input logic [10:0] f);
      logic [31:0] r;
      r = rnd();
      i_mic_line_model.send_rx(a, r[3:0], r[11:4], r[15:12], f);
      if (a && f[6]) exp_disc++;
      rd(OFS_RX_CHAR, {16'h0, a ? prio(f) : r[15:12], r[3:0], r[11:4]});
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   // monitor: completed reads, load pulses, discards, hang limit
   always @(posedge clock_i) begin
      if (psel && penable && pready_o && !pwrite) begin
         mon_exp = rd_q.pop_front();
         `CHK({pslverr_o, prdata_o}, mon_exp)
      end
      if (lc_load_o === 1'b1) begin
         `CHK({lc_line_o, lc_data_o}, lc_q.pop_front())
      end
      if (rx_discard_o === 1'b1) n_disc++;
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         print_verdict();
      end
   end

   initial begin
      logic [31:0] r;
      repeat (16) @(posedge clock_i);
      reset_n <= 1'b1;
      rd(OFS_RX_CHAR, 32'h0);
      rd(OFS_TXCOND, 32'h0);
      rd(OFS_SEL, 32'h0);
      rd(8'h1c, 32'h0, 1'b1);
      `CHK(irq_o, 1'b0)
      done("reset");
      for (int i = 0; i < 11; i++) rx(1'b1, 11'h1 << i);
      rx(1'b1, 11'h038);
      rx(1'b1, 11'h028);
      rx(1'b1, 11'h018);
      rx(1'b1, 11'h008);
      rx(1'b0, 11'h038);
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         rx(r[11], r[10:0]);
      end
      done("receive codes");
      wr(OFS_INT_MASK, 32'h3);
      rx(1'b1, 11'h040);
      `CHK(irq_o, 1'b1)
      rd(OFS_INT_STAT, 32'h1);
      wr(OFS_INT_STAT, 32'h1);
      rd(OFS_INT_STAT, 32'h0);
      `CHK(irq_o, 1'b0)
      wr(OFS_INT_MASK, 32'h0);
      i_mic_line_model.send_tx(4'h1, 3'h1);
      rd(OFS_INT_STAT, 32'h2);
      `CHK(irq_o, 1'b0)
      wr(OFS_INT_STAT, 32'h2);
      done("interrupt");
      wr(OFS_SEL, {20'h0, LINE_STATE_IDX, 8'h0a});
      wr(OFS_ACCESS, 32'h0);
      for (int k = 0; k < 8; k++) begin
         i_mic_line_model.send_tx(4'ha, k[2:0]);
         rd(OFS_TXCOND, {20'h0, txc[k], 8'h0a});
         if (k == 4) rd(OFS_ACCESS, 32'h1);
      end
      // parity replaces the nxm mark; kinds 6 and 7 leave the log alone
      rd(OFS_ACCESS, 32'h2);
      done("transmit codes");
      r = rnd();
      wr(OFS_SEL, 32'h0503);
      rd(OFS_SEL, 32'h0503);
      wr(OFS_ACCESS, {16'h0, r[15:0]});
      wr(OFS_SEL, 32'h0504);
      wr(OFS_ACCESS, {16'h0, r[31:16]});
      rd(OFS_ACCESS, {16'h0, r[31:16]});
      wr(OFS_SEL, 32'h0503);
      rd(OFS_ACCESS, {16'h0, r[15:0]});
      done("secondary access");
      wr(OFS_SEL, 32'h0006);
      r = rnd();
      lc_q.push_back({4'h6, r[14:0]});
      wr(OFS_LCLOAD, {17'h0, r[14:0]});
      rd(OFS_LCLOAD, {16'h0, 1'b1, r[14:0]});
      for (int i = 0; i < 20 && lc_load_o !== 1'b1; i++) @(posedge clock_i);
      rd(OFS_LCLOAD, {16'h0, 1'b0, r[14:0]});
      wr(OFS_SEL, 32'h0007);
      done("line control load");
      `CHK(n_disc, exp_disc)
      `CHK(lc_q.size(), 0)
      print_verdict();
   end
endmodule // mic_report_tb_top
